// >>> cbseq_pkg.sv
// constants, types and the micro-sequence table of the bus cycle sequencer
// assumes one clock; the instruction class is chosen by the decoder in front of it

package cbseq_pkg;

	localparam int STEP_W = 3;

	// ----------------------------------------------------------------
	// instruction classes handed in by the decoder
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		CBSEQ_ADD_HL  = 4'h0,
		CBSEQ_ALU_REG = 4'h1,
		CBSEQ_ALU_IMM = 4'h2,
		CBSEQ_ALU_HL  = 4'h3,
		CBSEQ_ALU_IDX = 4'h4,
		CBSEQ_ADD_IDX = 4'h5,
		CBSEQ_BIT_REG = 4'h6,
		CBSEQ_BIT_HL  = 4'h7,
		CBSEQ_BIT_IDX = 4'h8,
		CBSEQ_CALL    = 4'h9
	} cbseq_class_type;

	// ----------------------------------------------------------------
	// kinds of machine cycle
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		CBSEQ_K_END    = 4'h0,
		CBSEQ_K_FETCH1 = 4'h1,
		CBSEQ_K_FETCH2 = 4'h2,
		CBSEQ_K_FETCH3 = 4'h3,
		CBSEQ_K_OPLO   = 4'h4,
		CBSEQ_K_OPHI   = 4'h5,
		CBSEQ_K_DISP   = 4'h6,
		CBSEQ_K_RDHL   = 4'h7,
		CBSEQ_K_RDIDX  = 4'h8,
		CBSEQ_K_IDLE   = 4'h9,
		CBSEQ_K_WRHI   = 4'ha,
		CBSEQ_K_WRLO   = 4'hb
	} cbseq_kind_type;

	// bus phases, one-hot
	typedef enum logic [4:0] {
		CBSEQ_P_WAIT = 5'h01,
		CBSEQ_P_T1   = 5'h02,
		CBSEQ_P_T2   = 5'h04,
		CBSEQ_P_T3   = 5'h08,
		CBSEQ_P_TI   = 5'h10
	} cbseq_phase_type;

	localparam logic [15:0] ADDR_RESET  = 16'h0000;
	localparam logic [7:0]  BYTE_RESET  = 8'h00;
	localparam logic [15:0] SP_HI_OFFS  = 16'h0001;
	localparam logic [15:0] SP_LO_OFFS  = 16'h0002;
	localparam logic [15:0] PA_STEP     = 16'h0001;

	// ----------------------------------------------------------------
	// machine cycle that follows step 0 (the opcode fetch) for each class
	// ----------------------------------------------------------------
	function automatic cbseq_kind_type cbseq_ucode(input cbseq_class_type cls,
		input logic [STEP_W-1:0] step, input logic cond);
		cbseq_kind_type k;
		k = CBSEQ_K_END;
		case (cls)
			CBSEQ_ADD_HL: begin
				if (step >= 3'h1 && step <= 3'h4) k = CBSEQ_K_IDLE;
			end
			CBSEQ_ALU_REG: begin
				if (step == 3'h1) k = CBSEQ_K_IDLE;
			end
			CBSEQ_ALU_IMM: begin
				if (step == 3'h1) k = CBSEQ_K_OPLO;
			end
			CBSEQ_ALU_HL: begin
				if (step == 3'h1) k = CBSEQ_K_RDHL;
			end
			CBSEQ_ALU_IDX: begin
				case (step)
					3'h1: k = CBSEQ_K_FETCH2;
					3'h2: k = CBSEQ_K_DISP;
					3'h3, 3'h4, 3'h5: k = CBSEQ_K_IDLE;
					3'h6: k = CBSEQ_K_RDIDX;
					default: k = CBSEQ_K_END;
				endcase
			end
			CBSEQ_ADD_IDX: begin
				if (step == 3'h1) k = CBSEQ_K_FETCH2;
				else if (step >= 3'h2 && step <= 3'h5) k = CBSEQ_K_IDLE;
			end
			CBSEQ_BIT_REG: begin
				if (step == 3'h1) k = CBSEQ_K_FETCH2;
			end
			CBSEQ_BIT_HL: begin
				if (step == 3'h1) k = CBSEQ_K_FETCH2;
				else if (step == 3'h2) k = CBSEQ_K_RDHL;
			end
			CBSEQ_BIT_IDX: begin
				case (step)
					3'h1: k = CBSEQ_K_FETCH2;
					3'h2: k = CBSEQ_K_DISP;
					3'h3: k = CBSEQ_K_FETCH3;
					3'h4: k = CBSEQ_K_RDIDX;
					default: k = CBSEQ_K_END;
				endcase
			end
			CBSEQ_CALL: begin
				case (step)
					3'h1: k = CBSEQ_K_OPLO;
					3'h2: k = cond ? CBSEQ_K_OPHI : CBSEQ_K_END;
					3'h3: k = CBSEQ_K_IDLE;
					3'h4: k = CBSEQ_K_WRHI;
					3'h5: k = CBSEQ_K_WRLO;
					default: k = CBSEQ_K_END;
				endcase
			end
			default: k = CBSEQ_K_END;
		endcase
		return k;
	endfunction

endpackage

// >>> cbseq_ucode_rom.sv
// micro-sequence table with registered read data
// assumes the address is presented one cycle before the kind is needed
`timescale 1ns/10ps

module cbseq_ucode_rom (
	input  wire logic                              clk,
	input  wire logic                              rst_n,
	input  wire cbseq_pkg::cbseq_class_type        cls,
	input  wire logic [cbseq_pkg::STEP_W-1:0]      step,
	input  wire logic                              cond,
	output cbseq_pkg::cbseq_kind_type              kind
);

	cbseq_pkg::cbseq_kind_type kind_reg;
	cbseq_pkg::cbseq_kind_type kind_next;

	always_comb begin
		kind_next = cbseq_pkg::cbseq_ucode(cls, step, cond);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			kind_reg <= cbseq_pkg::CBSEQ_K_END;
		end else begin
			kind_reg <= kind_next;
		end
	end

	assign kind = kind_reg;

endmodule

// >>> cbseq_addr_unit.sv
// address selection for each kind of machine cycle
// purely combinational; the sequencer registers the result
`timescale 1ns/10ps

module cbseq_addr_unit (
	input  wire cbseq_pkg::cbseq_kind_type kind,
	input  wire logic [15:0]               prog_addr,
	input  wire logic [15:0]               hl_value,
	input  wire logic [15:0]               index_value,
	input  wire logic [7:0]                disp,
	input  wire logic [15:0]               sp_value,
	input  wire logic [15:0]               hold_addr,
	output logic [15:0]                    addr
);

	always_comb begin
		case (kind)
			cbseq_pkg::CBSEQ_K_RDHL:  addr = hl_value;
			cbseq_pkg::CBSEQ_K_RDIDX: addr = index_value + {{8{disp[7]}}, disp};
			cbseq_pkg::CBSEQ_K_WRHI:  addr = sp_value - cbseq_pkg::SP_HI_OFFS;
			cbseq_pkg::CBSEQ_K_WRLO:  addr = sp_value - cbseq_pkg::SP_LO_OFFS;
			// address is undefined while idle, so just hold it
			cbseq_pkg::CBSEQ_K_IDLE:  addr = hold_addr;
			cbseq_pkg::CBSEQ_K_END:   addr = hold_addr;
			default:                  addr = prog_addr;
		endcase
	end

endmodule

// >>> cbseq_sequencer.sv
// bus cycle sequencer: drives address, data and strobes per machine cycle
// assumes memory runs on clk and holds read data valid at the T3 edge;
// one clock is one bus state, a bus cycle is T1 T2 T3 and an idle state is one clock
`timescale 1ns/10ps

module cbseq_sequencer (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        instr_start,
	input  wire logic [3:0]  instr_class,
	input  wire logic        cond_true,
	input  wire logic [15:0] prog_addr,
	input  wire logic [15:0] hl_value,
	input  wire logic [15:0] index_value,
	input  wire logic [15:0] sp_value,
	input  wire logic [7:0]  bus_data_in,
	output logic [15:0]      address,
	output logic [7:0]       data_out,
	output logic             data_oe,
	output logic             rd_n,
	output logic             wr_n,
	output logic             memory_request_n,
	output logic             io_request_n,
	output logic             opcode_fetch_n,
	output logic             halt_n,
	output logic             status_n,
	output logic             busy,
	output logic             done,
	output logic [7:0]       read_data,
	output logic             read_valid,
	output logic [15:0]      call_target,
	output logic [15:0]      next_prog_addr
);

	// ----------------------------------------------------------------
	// sequence state
	// ----------------------------------------------------------------
	cbseq_pkg::cbseq_phase_type      phase_reg, phase_next;
	cbseq_pkg::cbseq_kind_type       kind_reg, kind_next;
	cbseq_pkg::cbseq_class_type      class_reg, class_next;
	logic                            cond_reg, cond_next;
	logic [cbseq_pkg::STEP_W-1:0]    step_reg, step_next;
	logic [cbseq_pkg::STEP_W-1:0]    rom_step;
	logic [15:0]                     pa_reg, pa_next;
	logic [7:0]                      lo_reg, lo_next;
	logic [7:0]                      hi_reg, hi_next;
	logic [7:0]                      disp_reg, disp_next;
	cbseq_pkg::cbseq_kind_type       rom_kind;
	logic                            advance;
	logic                            finish;

	// ----------------------------------------------------------------
	// table lookup
	// ----------------------------------------------------------------
	cbseq_ucode_rom u_rom (
		.clk   (clk),
		.rst_n (rst_n),
		.cls   (class_next),
		.step  (rom_step),
		.cond  (cond_next),
		.kind  (rom_kind)
	);

	// the table is read one step ahead so its registered output is ready in time
	always_comb begin
		rom_step = step_next + 3'h1;
	end

	// ----------------------------------------------------------------
	// next machine cycle and bus state
	// ----------------------------------------------------------------
	// a start is only looked at in WAIT, so one held while busy is dropped
	// the done cycle is WAIT as well, which lets instructions run back to back
	always_comb begin
		phase_next = phase_reg;
		kind_next  = kind_reg;
		class_next = class_reg;
		cond_next  = cond_reg;
		step_next  = step_reg;
		pa_next    = pa_reg;
		lo_next    = lo_reg;
		hi_next    = hi_reg;
		disp_next  = disp_reg;
		advance    = 1'b0;
		finish     = 1'b0;
		case (phase_reg)
			cbseq_pkg::CBSEQ_P_WAIT: begin
				if (instr_start) begin
					class_next = cbseq_pkg::cbseq_class_type'(instr_class);
					cond_next  = cond_true;
					step_next  = '0;
					pa_next    = prog_addr;
					kind_next  = cbseq_pkg::CBSEQ_K_FETCH1;
					phase_next = cbseq_pkg::CBSEQ_P_T1;
				end
			end
			cbseq_pkg::CBSEQ_P_T1: phase_next = cbseq_pkg::CBSEQ_P_T2;
			cbseq_pkg::CBSEQ_P_T2: phase_next = cbseq_pkg::CBSEQ_P_T3;
			cbseq_pkg::CBSEQ_P_T3: begin
				advance = 1'b1;
				case (kind_reg)
					cbseq_pkg::CBSEQ_K_FETCH1, cbseq_pkg::CBSEQ_K_FETCH2,
					cbseq_pkg::CBSEQ_K_FETCH3: pa_next = pa_reg + cbseq_pkg::PA_STEP;
					cbseq_pkg::CBSEQ_K_OPLO: begin
						lo_next = bus_data_in;
						pa_next = pa_reg + cbseq_pkg::PA_STEP;
					end
					cbseq_pkg::CBSEQ_K_OPHI: begin
						hi_next = bus_data_in;
						pa_next = pa_reg + cbseq_pkg::PA_STEP;
					end
					cbseq_pkg::CBSEQ_K_DISP: begin
						disp_next = bus_data_in;
						pa_next   = pa_reg + cbseq_pkg::PA_STEP;
					end
					default: pa_next = pa_reg;
				endcase
			end
			cbseq_pkg::CBSEQ_P_TI: advance = 1'b1;
			default: phase_next = cbseq_pkg::CBSEQ_P_WAIT;
		endcase
		if (advance) begin
			step_next = step_reg + 3'h1;
			kind_next = rom_kind;
			if (rom_kind == cbseq_pkg::CBSEQ_K_END) begin
				finish     = 1'b1;
				phase_next = cbseq_pkg::CBSEQ_P_WAIT;
			end else if (rom_kind == cbseq_pkg::CBSEQ_K_IDLE) begin
				phase_next = cbseq_pkg::CBSEQ_P_TI;
			end else begin
				phase_next = cbseq_pkg::CBSEQ_P_T1;
			end
		end
	end

	// ----------------------------------------------------------------
	// state registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_reg <= cbseq_pkg::CBSEQ_P_WAIT;
			kind_reg  <= cbseq_pkg::CBSEQ_K_END;
			class_reg <= cbseq_pkg::CBSEQ_ADD_HL;
			cond_reg  <= 1'b0;
			step_reg  <= '0;
			pa_reg    <= cbseq_pkg::ADDR_RESET;
			lo_reg    <= cbseq_pkg::BYTE_RESET;
			hi_reg    <= cbseq_pkg::BYTE_RESET;
			disp_reg  <= cbseq_pkg::BYTE_RESET;
		end else begin
			phase_reg <= phase_next;
			kind_reg  <= kind_next;
			class_reg <= class_next;
			cond_reg  <= cond_next;
			step_reg  <= step_next;
			pa_reg    <= pa_next;
			lo_reg    <= lo_next;
			hi_reg    <= hi_next;
			disp_reg  <= disp_next;
		end
	end

	// ----------------------------------------------------------------
	// kind decoding shared by strobes and read capture
	// ----------------------------------------------------------------
	// write cycles drive the data bus and never capture read data
	function automatic logic kind_is_write(input cbseq_pkg::cbseq_kind_type k);
		return (k == cbseq_pkg::CBSEQ_K_WRHI) || (k == cbseq_pkg::CBSEQ_K_WRLO);
	endfunction

	function automatic logic kind_is_fetch(input cbseq_pkg::cbseq_kind_type k);
		return (k == cbseq_pkg::CBSEQ_K_FETCH1) || (k == cbseq_pkg::CBSEQ_K_FETCH2) ||
			(k == cbseq_pkg::CBSEQ_K_FETCH3);
	endfunction

	// ----------------------------------------------------------------
	// pin values, computed from the next state (read capture from the current state) so every pin is a flop
	// ----------------------------------------------------------------
	logic [15:0] address_reg, address_next, addr_sel;
	logic [7:0]  data_out_reg, data_out_next;
	logic        data_oe_reg, data_oe_next;
	logic        rd_n_reg, rd_n_next;
	logic        wr_n_reg, wr_n_next;
	logic        memory_request_n_n_reg, memory_request_n_n_next;
	logic        fetch_n_reg, fetch_n_next;
	logic        status_n_reg, status_n_next;
	logic        busy_reg, busy_next;
	logic        done_reg, done_next;
	logic [7:0]  read_data_reg, read_data_next;
	logic        read_valid_reg, read_valid_next;
	logic        in_bus, is_read, is_write, is_fetch;

	cbseq_addr_unit u_addr (
		.kind        (kind_next),
		.prog_addr   (pa_next),
		.hl_value    (hl_value),
		.index_value (index_value),
		.disp        (disp_next),
		.sp_value    (sp_value),
		.hold_addr   (address_reg),
		.addr        (addr_sel)
	);

	always_comb begin
		in_bus   = (phase_next == cbseq_pkg::CBSEQ_P_T1) ||
			(phase_next == cbseq_pkg::CBSEQ_P_T2) ||
			(phase_next == cbseq_pkg::CBSEQ_P_T3);
		is_write = kind_is_write(kind_next);
		is_fetch = kind_is_fetch(kind_next);
		is_read  = in_bus && !is_write;
		address_next    = in_bus ? addr_sel : address_reg;
		// idle and wait: every strobe high, data released
		rd_n_next       = !is_read;
		wr_n_next       = !(in_bus && is_write);
		memory_request_n_n_next     = !in_bus;
		fetch_n_next    = !(in_bus && is_fetch);
		status_n_next   = !(in_bus && kind_next == cbseq_pkg::CBSEQ_K_FETCH1);
		data_oe_next    = in_bus && is_write;
		// return address is the program address after the operand bytes
		if (kind_next == cbseq_pkg::CBSEQ_K_WRHI) begin
			data_out_next = pa_reg[15:8];
		end else if (kind_next == cbseq_pkg::CBSEQ_K_WRLO) begin
			data_out_next = pa_reg[7:0];
		end else begin
			data_out_next = data_out_reg;
		end
		busy_next       = phase_next != cbseq_pkg::CBSEQ_P_WAIT;
		done_next       = finish;
		read_valid_next = (phase_reg == cbseq_pkg::CBSEQ_P_T3) && !kind_is_write(kind_reg);
		read_data_next  = read_valid_next ? bus_data_in : read_data_reg;
	end

	// ----------------------------------------------------------------
	// pin registers
	// ----------------------------------------------------------------
	// every pin but io_request_n, halt_n, call_target and next_prog_addr comes from here; those come from other flops on clk
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			address_reg    <= cbseq_pkg::ADDR_RESET;
			data_out_reg   <= cbseq_pkg::BYTE_RESET;
			data_oe_reg    <= 1'b0;
			rd_n_reg       <= 1'b1;
			wr_n_reg       <= 1'b1;
			memory_request_n_n_reg     <= 1'b1;
			fetch_n_reg    <= 1'b1;
			status_n_reg   <= 1'b1;
			busy_reg       <= 1'b0;
			done_reg       <= 1'b0;
			read_data_reg  <= cbseq_pkg::BYTE_RESET;
			read_valid_reg <= 1'b0;
		end else begin
			address_reg    <= address_next;
			data_out_reg   <= data_out_next;
			data_oe_reg    <= data_oe_next;
			rd_n_reg       <= rd_n_next;
			wr_n_reg       <= wr_n_next;
			memory_request_n_n_reg     <= memory_request_n_n_next;
			fetch_n_reg    <= fetch_n_next;
			status_n_reg   <= status_n_next;
			busy_reg       <= busy_next;
			done_reg       <= done_next;
			read_data_reg  <= read_data_next;
			read_valid_reg <= read_valid_next;
		end
	end

	// ----------------------------------------------------------------
	// strobes this block never asserts
	// ----------------------------------------------------------------
	// i/o and halt never assert in the cycles this block sequences
	// kept as flops so they switch with the same timing as the other strobes
	logic io_n_reg;
	logic halt_n_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			io_n_reg   <= 1'b1;
			halt_n_reg <= 1'b1;
		end else begin
			io_n_reg   <= 1'b1;
			halt_n_reg <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// call_target and next_prog_addr come straight from the sequence registers
	assign address          = address_reg;
	assign data_out         = data_out_reg;
	assign data_oe          = data_oe_reg;
	assign rd_n             = rd_n_reg;
	assign wr_n             = wr_n_reg;
	assign memory_request_n = memory_request_n_n_reg;
	assign io_request_n     = io_n_reg;
	assign opcode_fetch_n   = fetch_n_reg;
	assign halt_n           = halt_n_reg;
	assign status_n         = status_n_reg;
	assign busy             = busy_reg;
	assign done             = done_reg;
	assign read_data        = read_data_reg;
	assign read_valid       = read_valid_reg;
	assign call_target      = {hi_reg, lo_reg};
	assign next_prog_addr   = pa_reg;

endmodule

// >>> cbseq_checker.sv
// ----------------------------------------------------------------
// checker: strobe combinations and cycle order of the sequencer
// ----------------------------------------------------------------
// assumes sp_value and prog_addr stay steady during an instruction
`timescale 1ns/10ps

module cbseq_checker (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        instr_start,
	input wire logic [15:0] prog_addr,
	input wire logic [15:0] sp_value,
	input wire logic [15:0] address,
	input wire logic        data_oe,
	input wire logic        rd_n,
	input wire logic        wr_n,
	input wire logic        memory_request_n,
	input wire logic        io_request_n,
	input wire logic        opcode_fetch_n,
	input wire logic        halt_n,
	input wire logic        status_n,
	input wire logic        busy,
	input wire logic        done
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	start_fetch_a:
		assert property (instr_start && !busy |=> busy && !opcode_fetch_n && !status_n
			&& address == $past(prog_addr)) else $error("opcode fetch not started");
	fetch_strobe_a:
		assert property (!opcode_fetch_n |-> !rd_n && !memory_request_n && wr_n)
			else $error("fetch without read strobes");
	status_span_a:
		assert property ($fell(status_n) |-> !status_n [*3] ##1 status_n)
			else $error("status low span wrong");
	idle_quiet_a:
		assert property (busy && memory_request_n |-> rd_n && wr_n && opcode_fetch_n
			&& status_n && !data_oe) else $error("idle state not quiet");
	read_cycle_a:
		assert property ($fell(rd_n) |-> (!rd_n && !memory_request_n) [*3])
			else $error("read cycle shorter than three states");
	call_write_a:
		assert property ($fell(wr_n) |-> (!wr_n && rd_n && data_oe
			&& address == sp_value - 16'h0001) [*3] ##1 (!wr_n && data_oe
			&& address == sp_value - 16'h0002) [*3] ##1 (wr_n && !data_oe))
			else $error("stack write pair wrong");
	idle_first_a:
		assert property ($fell(wr_n) |-> $past(memory_request_n))
			else $error("no idle state before stack write");
	io_halt_a:
		assert property (io_request_n && halt_n) else $error("io or halt strobe low");
	done_pulse_a:
		assert property ($fell(busy) |-> done ##1 !done) else $error("done not one pulse");

	cover property ($fell(wr_n));
	cover property (!status_n ##3 !opcode_fetch_n && status_n);
	cover property (busy && memory_request_n [*4]);
	cover property (done && instr_start);
endmodule

bind cbseq_sequencer cbseq_checker chk (.clk, .rst_n, .instr_start, .prog_addr, .sp_value,
	.address, .data_oe, .rd_n, .wr_n, .memory_request_n, .io_request_n, .opcode_fetch_n,
	.halt_n, .status_n, .busy, .done);

// >>> cbseq_mem_model.sv
// memory on the far side of the sequencer's bus
// assumes the same clock as the sequencer and no wait states
`timescale 1ns/10ps

module cbseq_mem_model (
	input  wire logic        clk,
	input  wire logic [15:0] address,
	input  wire logic        rd_n,
	input  wire logic        wr_n,
	input  wire logic        memory_request_n,
	input  wire logic [7:0]  data_out,
	output logic      [7:0]  bus_data_in,
	output logic      [15:0] wr_addr_reg,
	output logic      [7:0]  wr_data_reg
);
	logic [7:0] last_reg = 8'h00;

	// a released bus toggles every cycle so a stale byte is never taken as data
	always_comb begin
		if (!rd_n && !memory_request_n) begin
			bus_data_in = address[7:0] ^ 8'ha5;
		end else begin
			bus_data_in = ~last_reg;
		end
	end

	always_ff @(posedge clk) begin
		last_reg <= bus_data_in;
		if (!wr_n && !memory_request_n) begin
			wr_addr_reg <= address;
			wr_data_reg <= data_out;
		end
	end
endmodule

// >>> tb_cpu_bus_cycle_sequencer.sv
// bench for the bus cycle sequencer: every class back to back, then odd cases
// assumes the memory model answers reads with address low byte xor a5
`timescale 1ns/10ps

module tb_cpu_bus_cycle_sequencer;
	// kinds: 1 first fetch, 2 later fetch, 3 operand, 4 read hl, 5 read indexed,
	// 6 idle, 7 write high, 8 write low; nibble 0 is the first machine cycle
	typedef struct {
		cbseq_pkg::cbseq_class_type cls;
		logic                       cond;
		int                         n;
		logic [31:0]                ks;
	} cbseq_row_type;

	localparam logic [15:0] PA = 16'h12fe;
	localparam logic [15:0] HL = 16'h4000;
	localparam logic [15:0] IX = 16'h8010;
	localparam logic [15:0] SP = 16'h0001;

	logic        clk;
	logic        rst_n;
	logic        instr_start;
	logic [3:0]  instr_class;
	logic        cond_true;
	logic [15:0] prog_addr;
	logic [15:0] hl_value;
	logic [15:0] index_value;
	logic [15:0] sp_value;
	logic [7:0]  bus_data_in;
	logic [15:0] address;
	logic [7:0]  data_out;
	logic        data_oe;
	logic        rd_n;
	logic        wr_n;
	logic        memory_request_n;
	logic        io_request_n;
	logic        opcode_fetch_n;
	logic        halt_n;
	logic        status_n;
	logic        busy;
	logic        done;
	logic [15:0] call_target;
	logic [7:0]  read_data;
	logic        read_valid;
	logic [15:0] next_prog_addr;
	logic [15:0] wr_addr;
	logic [7:0]  wr_data;
	int          fails;
	int          samples_checked;
	int          n;

	cbseq_row_type rows [11] = '{
		'{cbseq_pkg::CBSEQ_ADD_HL, 1'b1, 5, 32'h00066661},
		'{cbseq_pkg::CBSEQ_ALU_REG, 1'b1, 2, 32'h00000061},
		'{cbseq_pkg::CBSEQ_ALU_IMM, 1'b1, 2, 32'h00000031},
		'{cbseq_pkg::CBSEQ_ALU_HL, 1'b1, 2, 32'h00000041},
		'{cbseq_pkg::CBSEQ_ALU_IDX, 1'b1, 7, 32'h05666321},
		'{cbseq_pkg::CBSEQ_ADD_IDX, 1'b1, 6, 32'h00666621},
		'{cbseq_pkg::CBSEQ_BIT_REG, 1'b1, 2, 32'h00000021},
		'{cbseq_pkg::CBSEQ_BIT_HL, 1'b1, 3, 32'h00000421},
		'{cbseq_pkg::CBSEQ_BIT_IDX, 1'b1, 5, 32'h00052321},
		'{cbseq_pkg::CBSEQ_CALL, 1'b1, 6, 32'h00876331},
		'{cbseq_pkg::CBSEQ_CALL, 1'b0, 2, 32'h00000031}};

	cbseq_sequencer dut (.clk(clk), .rst_n(rst_n), .instr_start(instr_start),
		.instr_class(instr_class), .cond_true(cond_true), .prog_addr(prog_addr),
		.hl_value(hl_value), .index_value(index_value), .sp_value(sp_value),
		.bus_data_in(bus_data_in), .address(address), .data_out(data_out),
		.data_oe(data_oe), .rd_n(rd_n), .wr_n(wr_n), .memory_request_n(memory_request_n),
		.io_request_n(io_request_n), .opcode_fetch_n(opcode_fetch_n), .halt_n(halt_n),
		.status_n(status_n), .busy(busy), .done(done), .read_data(read_data),
		.read_valid(read_valid), .call_target(call_target),
		.next_prog_addr(next_prog_addr));

	cbseq_mem_model mem (.clk(clk), .address(address), .rd_n(rd_n), .wr_n(wr_n),
		.memory_request_n(memory_request_n), .data_out(data_out),
		.bus_data_in(bus_data_in), .wr_addr_reg(wr_addr), .wr_data_reg(wr_data));

	initial clk = 1'b0;
	always #20 clk = ~clk;

	function automatic logic [7:0] mem_byte(input logic [15:0] a);
		return a[7:0] ^ 8'ha5;
	endfunction

	// {rd_n, wr_n, memory_request_n, opcode_fetch_n, status_n, data_oe}
	function automatic logic [5:0] exp_st(input logic [3:0] k);
		case (k)
			4'h1: return 6'h10;
			4'h2: return 6'h12;
			4'h3, 4'h4, 4'h5: return 6'h16;
			4'h6: return 6'h3e;
			default: return 6'h27;
		endcase
	endfunction

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic start(input int i);
		instr_class <= rows[i].cls;
		cond_true <= rows[i].cond;
		instr_start <= 1'b1;
	endtask

	task automatic chk_reset();
		chk("reset strobes", 16'h03f8, {6'h00, rd_n, wr_n, memory_request_n, io_request_n,
			opcode_fetch_n, halt_n, status_n, data_oe, busy, done});
		chk("reset address", 16'h0000, address);
	endtask

	// start of row i is already raised; the next row is raised in the done cycle
	task automatic run(input int i);
		logic [3:0]  k;
		logic [15:0] ea;
		logic [15:0] pc;
		logic [7:0]  d;
		logic [5:0]  st;
		logic [7:0]  lb;
		int          f;
		f = 0;
		d = mem_byte(PA + 16'h0002);
		pc = PA + 16'h0003;
		@(posedge clk);
		instr_start <= 1'b0;
		for (int j = 0; j < rows[i].n; j++) begin
			k = rows[i].ks[4*j +: 4];
			case (k)
				4'h1, 4'h2, 4'h3: ea = PA + 16'(f);
				4'h4: ea = HL;
				4'h5: ea = IX + {{8{d[7]}}, d};
				4'h7: ea = SP - 16'h0001;
				default: ea = SP - 16'h0002;
			endcase
			repeat ((k == 4'h6) ? 1 : 3) begin
				#1;
				st = {rd_n, wr_n, memory_request_n, opcode_fetch_n, status_n, data_oe};
				chk("strobes", {10'h000, exp_st(k)}, {10'h000, st});
				chk("io halt", 16'h0003, {14'h0000, io_request_n, halt_n});
				if (k != 4'h6) chk("address", ea, address);
				if (k == 4'h7) chk("pc high", {8'h00, pc[15:8]}, {8'h00, data_out});
				if (k == 4'h8) chk("pc low", {8'h00, pc[7:0]}, {8'h00, data_out});
				@(posedge clk);
			end
			if (k < 4'h6) lb = mem_byte(ea);
			if (k < 4'h4) f++;
		end
		if (i < 10) start(i + 1);
		#1;
		chk("done", 16'h0001, {15'h0000, done});
		chk("busy", 16'h0000, {15'h0000, busy});
		chk("read valid", {15'h0000, (k < 4'h6)}, {15'h0000, read_valid});
		chk("read data", {8'h00, lb}, {8'h00, read_data});
		chk("next address", PA + 16'(f), next_prog_addr);
		if (i == 9) begin
			chk("call target", {mem_byte(PA + 16'h0002), mem_byte(PA + 16'h0001)}, call_target);
			chk("stack addr", SP - 16'h0002, wr_addr);
			chk("stack byte", {8'h00, pc[7:0]}, {8'h00, wr_data});
		end
	endtask

	initial begin
		#(40 * 3000);
		fails++;
		wrap_up();
	end

	initial begin
		fails = 0;
		samples_checked = 0;
		rst_n = 1'b0;
		instr_start = 1'b0;
		instr_class = 4'h0;
		cond_true = 1'b1;
		prog_addr = PA;
		hl_value = HL;
		index_value = IX;
		sp_value = SP;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk_reset();
		@(posedge clk);
		start(0);
		for (int i = 0; i < 11; i++) run(i);
		// a start held while busy must not open a second instruction
		@(posedge clk);
		start(1);
		n = 0;
		for (int j = 0; j < 10; j++) begin
			@(posedge clk);
			if (j == 2) instr_start <= 1'b0;
			#1;
			if (busy === 1'b1) n++;
		end
		chk("busy span", 16'h0004, 16'(n));
		// reset in the middle of the stack writes, then a clean instruction
		@(posedge clk);
		start(9);
		@(posedge clk);
		instr_start <= 1'b0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b0;
		#1;
		chk_reset();
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		start(10);
		run(10);
		wrap_up();
	end
endmodule
